// ===== hw/nfcs_params.svh
// Command codes, limits and timing counts of the NAND host sequencer
// Behaviour
// R1: Only codes from the defined command set are driven in a command cycle.
// R2: After serial input 80h the only following commands are 10h or FFh.
// R3: A program cut short by any other command is not run; FFh follows.
// R4: Status read 70h during a read makes the next strobe return status.
// R5: Held in status mode after a read, strobes return no page data.
// R6: Read command 00h cancels status mode; output resumes at current column; the device model resets the column to 0 on 00h.
// R7: Write-protect low aborts and resets any program or erase in progress.
// R8: Address takes three cycles; a fourth address cycle is ignored.
// R9: At most five partial program operations on one page before erase; the code counts only the most recently programmed page.
// R10: Each output strobe in read mode advances the column counter by one.
// R11: After 00h/01h/50h strobes advance column; past the end starts sequential load.
// R12: Output strobes in read mode come only after address input completes.
// R13: After each erase read status; a failed block is replaced; the code only marks it bad.
// R14: After each page program read status; a failed block is retired.
// R15: Single-bit program failures are handled by verify-and-retry or ECC; the code marks the block bad instead.
// R16: A block that failed erase receives no further access.
// R17: Chip select may be at either level in read and program intervals.
// R18: Bad blocks exist, as few as 1014 of 1024 valid; track and skip.
// R19: Array-to-register load finishes within 7 us with busy asserted.
// R20: Reset returns ready within 5, 10 or 500 us for read, program, erase.
// R21: Last column is 527; reading past it starts the next page load.
// R22: Busy is held for the whole internal operation and released at its end.
`ifndef NFCS_PARAMS_SVH
`define NFCS_PARAMS_SVH

`define NFCS_CLK_NS       50
`define NFCS_CYC_UP(ns)   (((ns) + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS)
`define NFCS_CYC_DN(ns)   ((ns) / `NFCS_CLK_NS)

`define NFCS_C_READ0      8'h00
`define NFCS_C_READ1      8'h01
`define NFCS_C_READ2      8'h50
`define NFCS_C_SERIAL     8'h80
`define NFCS_C_PROG       8'h10
`define NFCS_C_ERASE      8'h60
`define NFCS_C_ERASE2     8'hD0
`define NFCS_C_STATUS     8'h70
`define NFCS_C_RESET      8'hFF

`define NFCS_PAGE_BYTES   11'h210
`define NFCS_MAX_PARTIAL  3'h5
`define NFCS_BLOCKS       1024
`define NFCS_STAT_FAIL    0

`define NFCS_T_WB_NS      100
`define NFCS_T_WHR_NS     60
`define NFCS_T_WW_NS      100
`define NFCS_T_R_US       7
`define NFCS_T_PROG_US    1000
`define NFCS_T_ERASE_MS   10
`define NFCS_T_RSTR_US    5
`define NFCS_T_RSTP_US    10
`define NFCS_T_RSTE_US    500

`endif

// ===== hw/nfcs_pkg.sv
// Types of the NAND host sequencer
package nfcs_pkg;
  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_PROG   = 3'b001,
    OP_ERASE  = 3'b010,
    OP_STATUS = 3'b011,
    OP_RESET  = 3'b100
  } nfcs_op_e;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CMD   = 3'b001,
    S_ADDR  = 3'b010,
    S_WDATA = 3'b011,
    S_BUSY  = 3'b100,
    S_GAP   = 3'b101,
    S_STRD  = 3'b110,
    S_RDATA = 3'b111
  } nfcs_state_e;

  typedef logic [17:0] nfcs_tmr_t;
endpackage : nfcs_pkg

// ===== hw/nfcs_buf2.sv
// Two-entry valid/ready buffer for read data
`timescale 1ns/1ns
module nfcs_buf2 (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Filling side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // Draining side
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready
);
  logic [7:0] mem_r [0:1];
  logic [1:0] cnt_r, cnt_nxt;
  logic       wp_r, wp_nxt;
  logic       rp_r, rp_nxt;
  logic       push, pop;
  // Registered head so the outputs of the top come straight from flops
  logic       ov_r, ov_nxt;
  logic [7:0] od_r, od_nxt;

  always_comb begin
    push    = in_valid && (cnt_r != 2'h2);
    pop     = out_ready && (cnt_r != 2'h0);
    wp_nxt  = push ? ~wp_r : wp_r;
    rp_nxt  = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    ov_nxt  = (cnt_nxt != 2'h0);
    od_nxt  = (push && (wp_r == rp_nxt)) ? in_data : mem_r[rp_nxt];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      ov_r  <= 1'b0;
      od_r  <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
      if (push) begin
        mem_r[wp_r] <= in_data;
      end
    end
  end

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = ov_r;
  assign out_data  = od_r;
endmodule : nfcs_buf2

// ===== hw/nfcs_host.sv
// Host-side command sequencer driving an asynchronous NAND flash port
`timescale 1ns/1ns
`include "nfcs_params.svh"
module nfcs_host #(
  parameter int PROG_CYC  = `NFCS_CYC_DN(`NFCS_T_PROG_US * 1000),
  parameter int ERASE_CYC = `NFCS_CYC_DN(`NFCS_T_ERASE_MS * 1000000),
  parameter int RSTE_CYC  = `NFCS_CYC_DN(`NFCS_T_RSTE_US * 1000)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Request port
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_op,
  input  wire logic [14:0] req_row,
  input  wire logic [9:0]  req_col,
  input  wire logic [9:0]  req_len,
  output logic             req_ready,
  output logic             done,
  output logic             refused,
  output logic             failed,
  output logic             timed_out,
  output logic [7:0]       status_byte,
  // Bad block marking
  input  wire logic        mark_bad,
  input  wire logic [9:0]  mark_block,
  // Program data
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  // Read data
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  input  wire logic        rd_ready,
  // Write protect request
  input  wire logic        wp_hold,
  // Flash pins
  output logic             cle,
  output logic             ale,
  output logic             ce_n,
  output logic             we_n,
  output logic             output_strobe_n,
  output logic             wp_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        rb
);
  localparam nfcs_pkg::nfcs_tmr_t WB_CYC  = 18'(`NFCS_CYC_UP(`NFCS_T_WB_NS));
  localparam nfcs_pkg::nfcs_tmr_t WHR_CYC = 18'(`NFCS_CYC_UP(`NFCS_T_WHR_NS));
  localparam logic [1:0]          WW_CYC  = 2'(`NFCS_CYC_UP(`NFCS_T_WW_NS));
  localparam nfcs_pkg::nfcs_tmr_t R_CYC   = 18'(`NFCS_CYC_DN(`NFCS_T_R_US * 1000));
  localparam nfcs_pkg::nfcs_tmr_t RSTR_C  = 18'(`NFCS_CYC_DN(`NFCS_T_RSTR_US * 1000));
  localparam nfcs_pkg::nfcs_tmr_t RSTP_C  = 18'(`NFCS_CYC_DN(`NFCS_T_RSTP_US * 1000));

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] ptr_cmd(input logic [9:0] col);
    case (col[9:8])
      2'h0:    ptr_cmd = `NFCS_C_READ0;
      2'h1:    ptr_cmd = `NFCS_C_READ1;
      default: ptr_cmd = `NFCS_C_READ2;
    endcase
  endfunction : ptr_cmd

  function automatic logic [7:0] addr_byte(input logic erase, input logic [1:0] cyc,
                                           input logic [14:0] row, input logic [9:0] col);
    logic [1:0] k;
    k = erase ? cyc + 2'h1 : cyc;
    case (k)
      2'h0:    addr_byte = col[7:0];
      2'h1:    addr_byte = row[7:0];
      default: addr_byte = {1'b0, row[14:8]};
    endcase
  endfunction : addr_byte

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  nfcs_pkg::nfcs_state_e state_r, state_nxt;
  nfcs_pkg::nfcs_op_e    op_r, op_nxt, from_r, from_nxt;
  nfcs_pkg::nfcs_tmr_t   tmr_r, tmr_nxt;
  logic [14:0] row_r, row_nxt, prow_r, prow_nxt;
  logic [9:0]  col_r, col_nxt, len_r, len_nxt;
  logic [7:0]  cmd_r, cmd_nxt, io_out_r, io_out_nxt, stat_r, stat_nxt, pdata_r, pdata_nxt;
  logic [2:0]  pcnt_r, pcnt_nxt;
  logic [1:0]  acyc_r, acyc_nxt, wpc_r, wpc_nxt;
  logic        phase_r, phase_nxt, push_r, push_nxt;
  logic        cle_r, cle_nxt, ale_r, ale_nxt, ce_n_r, ce_n_nxt;
  logic        we_n_r, we_n_nxt, rs_n_r, rs_n_nxt, wp_n_r, wp_n_nxt, oe_r, oe_nxt;
  logic        rdy_r, rdy_nxt, done_r, done_nxt, ref_r, ref_nxt;
  logic        fail_r, fail_nxt, tmo_r, tmo_nxt, wrr_r, wrr_nxt;
  logic        bad_r [0:`NFCS_BLOCKS-1];
  logic        bad_set, accept, is_arr, buf_ready;
  logic [10:0] span;
  nfcs_pkg::nfcs_op_e rop;

  assign rop    = nfcs_pkg::nfcs_op_e'(req_op);
  assign accept = (state_r == nfcs_pkg::S_IDLE) && req_valid && rdy_r;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;   op_nxt = op_r;       from_nxt = from_r;
    row_nxt   = row_r;     col_nxt = col_r;     len_nxt = len_r;
    prow_nxt  = prow_r;    pcnt_nxt = pcnt_r;   cmd_nxt = cmd_r;
    acyc_nxt  = acyc_r;    phase_nxt = phase_r; io_out_nxt = io_out_r;
    stat_nxt  = stat_r;    pdata_nxt = pdata_r; push_nxt = 1'b0;
    cle_nxt   = cle_r;     ale_nxt = ale_r;     ce_n_nxt = ce_n_r;
    we_n_nxt  = we_n_r;    rs_n_nxt = rs_n_r;   oe_nxt = oe_r;
    rdy_nxt   = 1'b0;      done_nxt = 1'b0;     ref_nxt = ref_r;
    fail_nxt  = fail_r;    tmo_nxt = tmo_r;     wrr_nxt = wrr_r;
    bad_set   = 1'b0;
    tmr_nxt   = (tmr_r != 18'h0) ? tmr_r - 18'h1 : tmr_r;
    wp_n_nxt  = ~wp_hold;
    // Write enable must stay clear of the protect edge, so requests wait
    wpc_nxt   = wp_hold ? WW_CYC : ((wpc_r != 2'h0) ? wpc_r - 2'h1 : wpc_r);
    is_arr    = (rop == nfcs_pkg::OP_READ) || (rop == nfcs_pkg::OP_PROG) || (rop == nfcs_pkg::OP_ERASE);
    span      = {1'b0, req_col} + {1'b0, req_len};
    case (state_r)
      nfcs_pkg::S_IDLE: begin
        rdy_nxt = !accept && !wp_hold && (wpc_r == 2'h0);
        if (accept) begin
          op_nxt = rop; row_nxt = req_row; col_nxt = req_col; len_nxt = req_len;
          ref_nxt = 1'b0; fail_nxt = 1'b0; tmo_nxt = 1'b0; from_nxt = rop;
          if (req_op > 3'h4 ||                                              // [R1]
              (is_arr && bad_r[req_row[14:5]]) ||                           // [R16] [R18]
              ((rop == nfcs_pkg::OP_READ || rop == nfcs_pkg::OP_PROG) &&
               (req_len == 10'h0 || span > `NFCS_PAGE_BYTES)) ||            // [R12] [R21]
              (rop == nfcs_pkg::OP_PROG && req_row == prow_r &&
               pcnt_r == `NFCS_MAX_PARTIAL)) begin                          // [R9]
            ref_nxt = 1'b1; done_nxt = 1'b1;
          end else begin
            state_nxt = nfcs_pkg::S_CMD; phase_nxt = 1'b0; ce_n_nxt = 1'b0;
            case (rop)
              nfcs_pkg::OP_READ, nfcs_pkg::OP_PROG: cmd_nxt = ptr_cmd(req_col); // [R11]
              nfcs_pkg::OP_ERASE:                   cmd_nxt = `NFCS_C_ERASE;
              nfcs_pkg::OP_STATUS:                  cmd_nxt = `NFCS_C_STATUS;
              default:                              cmd_nxt = `NFCS_C_RESET;
            endcase
            if (rop == nfcs_pkg::OP_PROG) begin                             // [R9]
              prow_nxt = req_row;
              pcnt_nxt = (req_row == prow_r) ? pcnt_r + 3'h1 : 3'h1;
            end
            if (rop == nfcs_pkg::OP_ERASE && req_row[14:5] == prow_r[14:5]) begin
              pcnt_nxt = 3'h0;
            end
          end
        end
      end
      nfcs_pkg::S_CMD: begin
        if (!phase_r) begin
          cle_nxt = 1'b1; ale_nxt = 1'b0; oe_nxt = 1'b1;
          io_out_nxt = cmd_r; we_n_nxt = 1'b0; phase_nxt = 1'b1;
        end else begin
          we_n_nxt = 1'b1; phase_nxt = 1'b0; acyc_nxt = 2'h0;
          case (cmd_r)
            `NFCS_C_SERIAL, `NFCS_C_ERASE: state_nxt = nfcs_pkg::S_ADDR;
            `NFCS_C_READ0, `NFCS_C_READ1, `NFCS_C_READ2: begin
              if (op_r == nfcs_pkg::OP_PROG) begin
                cmd_nxt = `NFCS_C_SERIAL;
              end else begin
                state_nxt = nfcs_pkg::S_ADDR;
              end
            end
            `NFCS_C_STATUS: begin
              state_nxt = nfcs_pkg::S_GAP; tmr_nxt = WHR_CYC;
            end
            default: begin
              state_nxt = nfcs_pkg::S_BUSY; tmr_nxt = WB_CYC;
            end
          endcase
        end
      end
      nfcs_pkg::S_ADDR: begin
        if (!phase_r) begin
          cle_nxt = 1'b0; ale_nxt = 1'b1; we_n_nxt = 1'b0; phase_nxt = 1'b1;
          io_out_nxt = addr_byte(op_r == nfcs_pkg::OP_ERASE, acyc_r, row_r, col_r);
        end else begin
          we_n_nxt = 1'b1; phase_nxt = 1'b0; acyc_nxt = acyc_r + 2'h1;
          // Three cycles for page access, two row cycles for erase
          if (acyc_r == ((op_r == nfcs_pkg::OP_ERASE) ? 2'h1 : 2'h2)) begin   // [R8]
            case (op_r)
              nfcs_pkg::OP_PROG: begin
                state_nxt = nfcs_pkg::S_WDATA; wrr_nxt = 1'b1;
              end
              nfcs_pkg::OP_ERASE: begin
                state_nxt = nfcs_pkg::S_CMD; cmd_nxt = `NFCS_C_ERASE2;
              end
              default: begin
                state_nxt = nfcs_pkg::S_BUSY; tmr_nxt = WB_CYC;
              end
            endcase
          end
        end
      end
      nfcs_pkg::S_WDATA: begin
        ale_nxt = 1'b0;
        if (!phase_r) begin
          if (wr_valid && wrr_r) begin
            io_out_nxt = wr_data; we_n_nxt = 1'b0; wrr_nxt = 1'b0;
            phase_nxt = 1'b1; len_nxt = len_r - 10'h1;
          end
        end else begin
          we_n_nxt = 1'b1; phase_nxt = 1'b0;
          if (len_r == 10'h0) begin
            state_nxt = nfcs_pkg::S_CMD; cmd_nxt = `NFCS_C_PROG;          // [R2]
          end else begin
            wrr_nxt = 1'b1;
          end
        end
      end
      nfcs_pkg::S_BUSY: begin
        cle_nxt = 1'b0; ale_nxt = 1'b0; oe_nxt = 1'b0;
        if (!phase_r) begin
          // Busy is not valid until the write-to-busy delay has passed
          if (tmr_r == 18'h0) begin
            phase_nxt = 1'b1;
            case (op_r)
              nfcs_pkg::OP_READ:  tmr_nxt = R_CYC;                          // [R19]
              nfcs_pkg::OP_PROG:  tmr_nxt = 18'(PROG_CYC);
              nfcs_pkg::OP_ERASE: tmr_nxt = 18'(ERASE_CYC);
              default: begin                                                // [R20]
                case (from_r)
                  nfcs_pkg::OP_READ: tmr_nxt = RSTR_C;
                  nfcs_pkg::OP_PROG: tmr_nxt = RSTP_C;
                  default:           tmr_nxt = 18'(RSTE_CYC);
                endcase
              end
            endcase
          end
        end else if (rb) begin                                              // [R22]
          phase_nxt = 1'b0;
          case (op_r)
            nfcs_pkg::OP_READ: state_nxt = nfcs_pkg::S_RDATA;
            nfcs_pkg::OP_PROG, nfcs_pkg::OP_ERASE: begin                    // [R13] [R14]
              state_nxt = nfcs_pkg::S_CMD; cmd_nxt = `NFCS_C_STATUS;
            end
            default: begin
              state_nxt = nfcs_pkg::S_IDLE; done_nxt = 1'b1; ce_n_nxt = 1'b1;
            end
          endcase
        end else if (tmr_r == 18'h0) begin
          tmo_nxt = 1'b1; phase_nxt = 1'b0;
          state_nxt = nfcs_pkg::S_IDLE; done_nxt = 1'b1; ce_n_nxt = 1'b1;
        end
      end
      nfcs_pkg::S_GAP: begin
        cle_nxt = 1'b0; oe_nxt = 1'b0;
        if (tmr_r == 18'h0) begin
          state_nxt = nfcs_pkg::S_STRD;
        end
      end
      nfcs_pkg::S_STRD: begin
        if (!phase_r) begin
          rs_n_nxt = 1'b0; phase_nxt = 1'b1;                                // [R4]
        end else begin
          rs_n_nxt = 1'b1; phase_nxt = 1'b0; stat_nxt = io_in;
          if ((op_r == nfcs_pkg::OP_PROG || op_r == nfcs_pkg::OP_ERASE) && io_in[`NFCS_STAT_FAIL]) begin
            fail_nxt = 1'b1; bad_set = 1'b1;                                // [R13] [R14] [R15]
          end
          state_nxt = nfcs_pkg::S_IDLE; done_nxt = 1'b1; ce_n_nxt = 1'b1;
        end
      end
      nfcs_pkg::S_RDATA: begin
        if (!phase_r) begin
          // One byte in flight at most, so a full buffer never drops one
          if (buf_ready && !push_r) begin
            rs_n_nxt = 1'b0; phase_nxt = 1'b1;                              // [R12]
          end
        end else begin
          rs_n_nxt = 1'b1; phase_nxt = 1'b0; push_nxt = 1'b1;
          pdata_nxt = io_in; len_nxt = len_r - 10'h1; col_nxt = col_r + 10'h1;  // [R10]
          if (len_r == 10'h1) begin                                         // [R21]
            state_nxt = nfcs_pkg::S_IDLE; done_nxt = 1'b1; ce_n_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = nfcs_pkg::S_IDLE;
    endcase
    // Protect low kills a program or erase; the reset command FFh is then issued
    if (wp_hold && (op_r == nfcs_pkg::OP_PROG || op_r == nfcs_pkg::OP_ERASE) &&
        state_r != nfcs_pkg::S_IDLE && state_r != nfcs_pkg::S_GAP &&
        state_r != nfcs_pkg::S_STRD && cmd_r != `NFCS_C_STATUS) begin      // [R7] [R3]
      state_nxt = nfcs_pkg::S_CMD; cmd_nxt = `NFCS_C_RESET; phase_nxt = 1'b0;
      op_nxt = nfcs_pkg::OP_RESET; from_nxt = op_r; we_n_nxt = 1'b1;
      wrr_nxt = 1'b0; fail_nxt = 1'b1; done_nxt = 1'b0; ce_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= nfcs_pkg::S_IDLE; op_r <= nfcs_pkg::OP_READ; from_r <= nfcs_pkg::OP_READ;
      tmr_r <= 18'h0; row_r <= 15'h0; prow_r <= 15'h7FFF; col_r <= 10'h0; len_r <= 10'h0;
      cmd_r <= 8'h00; io_out_r <= 8'h00; stat_r <= 8'h00; pdata_r <= 8'h00;
      pcnt_r <= 3'h0; acyc_r <= 2'h0; wpc_r <= WW_CYC; phase_r <= 1'b0; push_r <= 1'b0;
      cle_r <= 1'b0; ale_r <= 1'b0; ce_n_r <= 1'b1; we_n_r <= 1'b1; rs_n_r <= 1'b1;
      wp_n_r <= 1'b0; oe_r <= 1'b0; rdy_r <= 1'b0; done_r <= 1'b0; ref_r <= 1'b0;
      fail_r <= 1'b0; tmo_r <= 1'b0; wrr_r <= 1'b0;
      for (int i = 0; i < `NFCS_BLOCKS; i++) begin
        bad_r[i] <= 1'b0;
      end
    end else begin
      state_r <= state_nxt; op_r <= op_nxt; from_r <= from_nxt; tmr_r <= tmr_nxt;
      row_r <= row_nxt; prow_r <= prow_nxt; col_r <= col_nxt; len_r <= len_nxt;
      cmd_r <= cmd_nxt; io_out_r <= io_out_nxt; stat_r <= stat_nxt; pdata_r <= pdata_nxt;
      pcnt_r <= pcnt_nxt; acyc_r <= acyc_nxt; wpc_r <= wpc_nxt; phase_r <= phase_nxt;
      push_r <= push_nxt; cle_r <= cle_nxt; ale_r <= ale_nxt; ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt; rs_n_r <= rs_n_nxt; wp_n_r <= wp_n_nxt; oe_r <= oe_nxt;
      rdy_r <= rdy_nxt; done_r <= done_nxt; ref_r <= ref_nxt; fail_r <= fail_nxt;
      tmo_r <= tmo_nxt; wrr_r <= wrr_nxt;
      if (bad_set) begin
        bad_r[row_r[14:5]] <= 1'b1;                                         // [R16]
      end
      if (mark_bad) begin
        bad_r[mark_block] <= 1'b1;                                          // [R18]
      end
    end
  end

  nfcs_buf2 u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_r),
    .in_data   (pdata_r),
    .in_ready  (buf_ready),
    .out_valid (rd_valid),
    .out_data  (rd_data),
    .out_ready (rd_ready)
  );

  assign req_ready = rdy_r;       assign done = done_r;      assign refused = ref_r;
  assign failed = fail_r;         assign timed_out = tmo_r;  assign status_byte = stat_r;
  assign wr_ready = wrr_r;        assign cle = cle_r;        assign ale = ale_r;
  assign ce_n = ce_n_r;           assign we_n = we_n_r;      assign output_strobe_n = rs_n_r;
  assign wp_n = wp_n_r;           assign io_out = io_out_r;  assign io_oe = oe_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic       h_cmd, h_a80_r, h_aok_r;
  logic [2:0] h_acnt_r;
  assign h_cmd = cle_r && !we_n_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      h_a80_r <= 1'b0; h_aok_r <= 1'b0; h_acnt_r <= 3'h0;
    end else begin
      if (h_cmd) begin
        h_a80_r  <= (io_out_r == `NFCS_C_SERIAL);
        h_aok_r  <= (io_out_r == `NFCS_C_STATUS);
        h_acnt_r <= 3'h0;
      end else if (ale_r && !we_n_r) begin
        h_aok_r  <= 1'b1;
        h_acnt_r <= h_acnt_r + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_cmd_defined: assert property (h_cmd |-> io_out_r inside {8'h00, 8'h01, 8'h50, 8'h80, 8'h10,
    8'h60, 8'hD0, 8'h70, 8'hFF}) else $error("undefined command driven"); // [R1]
  a_serial_follow: assert property (h_cmd && h_a80_r |-> io_out_r inside {8'h10, 8'hFF})
    else $error("bad command after serial input"); // [R2]
  a_wp_abort: assert property (wp_hold && op_r == nfcs_pkg::OP_PROG && cmd_r != 8'h70 && // [R7] [R3]
    state_r inside {nfcs_pkg::S_CMD, nfcs_pkg::S_WDATA, nfcs_pkg::S_BUSY} |=>
    state_r == nfcs_pkg::S_CMD && cmd_r == 8'hFF ##1 h_cmd && io_out_r == 8'hFF)
    else $error("protect did not reset program");
  a_three_addr: assert property (ale_r && !we_n_r |-> h_acnt_r < 3'h3)
    else $error("more than three address cycles"); // [R8]
  a_partial_limit: assert property (accept && rop == nfcs_pkg::OP_PROG && req_row == prow_r &&
    pcnt_r == 3'h5 |=> ref_r && done_r) else $error("sixth partial program not refused"); // [R9]
  a_strobe_addr: assert property (!rs_n_r |-> h_aok_r) else $error("strobe before address"); // [R12]
  a_status_after: assert property (state_r == nfcs_pkg::S_BUSY && phase_r && rb && !wp_hold &&
    op_r inside {nfcs_pkg::OP_PROG, nfcs_pkg::OP_ERASE} |=> cmd_r == 8'h70 ##1 h_cmd)
    else $error("no status read after program or erase"); // [R13] [R14]
  a_bad_refused: assert property (accept && is_arr && bad_r[req_row[14:5]] |=> ref_r && done_r)
    else $error("access to bad block not refused"); // [R16]
  a_strobe_pulse: assert property ($fell(rs_n_r) |=> rs_n_r ##1 rs_n_r)
    else $error("strobe pulse shape wrong"); // [R10]

  c_read_done: cover property (state_r == nfcs_pkg::S_RDATA ##[1:1000] done_r && !ref_r);
  c_prog_done: cover property (op_r == nfcs_pkg::OP_PROG && done_r && !fail_r);
  c_erase_fail: cover property (op_r == nfcs_pkg::OP_ERASE && done_r && fail_r);
  c_wp_abort: cover property (wp_hold && op_r == nfcs_pkg::OP_PROG && state_r == nfcs_pkg::S_BUSY);
endmodule : nfcs_host

// ===== sim/nfcs_dev.sv
// Behavioural NAND device answering the host sequencer's pins
`timescale 1ns/1ns
module nfcs_dev (
  // Host pins; chip select is not watched, either level is accepted
  input  wire logic       clock, cle, ale, we_n, output_strobe_n, wp_n,
  input  wire logic [7:0] io_out,
  // Answers and forced status fail
  output logic [7:0]      io_in,
  output logic            rb,
  input  wire logic       fail
);
  logic [9:0] col_r = 0;
  logic [1:0] adr_r = 0;
  logic       stat_r = 0, rdm_r = 0, pe_r = 0;
  int         busy_r = 0;
  wire  [7:0] val = stat_r ? {7'h30, fail} : col_r[7:0] ^ 8'h5A;
  // Released bus shows the inverse so a stale byte never passes
  assign io_in = output_strobe_n ? ~val : val;
  assign rb    = busy_r == 0;
  always @(posedge clock) begin
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (!we_n && cle) begin
      adr_r <= 0;
      if (io_out inside {8'h00, 8'h01, 8'h50}) begin
        rdm_r <= 1;
        col_r <= {io_out == 8'h50, io_out == 8'h01, 8'h00};
      end
      if (io_out == 8'h00) stat_r <= 0;
      if (io_out == 8'h70) stat_r <= 1;
      if (io_out inside {8'h80, 8'h60}) rdm_r <= 0;
      if (io_out inside {8'h10, 8'hD0}) begin busy_r <= 20; pe_r <= 1; end
      if (io_out == 8'hFF) busy_r <= 5;
    end
    if (!we_n && ale && adr_r != 3) begin
      adr_r <= adr_r + 2'h1;
      if (adr_r == 0) col_r[7:0] <= io_out;
      if (adr_r == 2 && rdm_r) busy_r <= 10;
    end
    if (!output_strobe_n && !stat_r) begin
      col_r <= col_r == 527 ? 10'h000 : col_r + 10'h001;
      if (col_r == 527) busy_r <= 10;
    end
    if (!wp_n && pe_r) begin busy_r <= 0; pe_r <= 0; end
  end
endmodule : nfcs_dev

// ===== sim/tb.sv
// Self-checking bench for the NAND host sequencer with a device model
`timescale 1ns/1ns
module tb;
  logic        clock = 0, rst_n = 0, req_valid = 0, rd_ready = 0, wp_hold = 0, fail = 0, arm = 0;
  logic        mark_bad = 0, wr_valid = 1;
  logic [9:0]  mark_block = 0, req_col = 0, req_len = 0, exp_col;
  logic [7:0]  wr_data = 8'hA5, status_byte, rd_data, io_out, io_in;
  logic [2:0]  req_op = 0;
  logic [14:0] req_row = 0;
  logic        req_ready, done, refused, failed, timed_out, wr_ready, rd_valid;
  logic        cle, ale, ce_n, we_n, output_strobe_n, wp_n, io_oe, rb;
  int          fails = 0, comparisons = 0, n, nb, tail;
  localparam logic [39:0] PG = {3'h1, 15'h20, 10'h0, 10'h2, 2'h0};
  localparam logic [39:0] ER = {3'h2, 15'h20, 10'h0, 10'h0, 2'h0};
  // Rows: op, row, column, length, refused, failed
  logic [39:0] rows [17] = '{{3'h3, 15'h0, 10'h0, 10'h0, 2'h0}, {3'h0, 15'h0, 10'h0, 10'h5, 2'h0},
    {3'h0, 15'h1, 10'h12C, 10'h3, 2'h0}, {3'h0, 15'h2, 10'h208, 10'h8, 2'h0}, {3'h5, 15'h0, 10'h0, 10'h1, 2'h2},
    {3'h0, 15'h0, 10'h0, 10'h0, 2'h2}, {3'h0, 15'h0, 10'h20F, 10'h2, 2'h2}, ER, PG, PG, PG, PG, PG,
    {3'h1, 15'h20, 10'h0, 10'h2, 2'h2}, ER, PG, {3'h4, 15'h0, 10'h0, 10'h0, 2'h0}};
  nfcs_host #(.PROG_CYC(50), .ERASE_CYC(80), .RSTE_CYC(40)) dut (.*);
  nfcs_dev dev (.*);
  initial forever #25 clock = ~clock;
  // Protect is raised only once the device reports a program busy
  always @(negedge clock) if (arm && !rb) wp_hold = 1;
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic do_req(input logic [39:0] r);
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge clock);
      if (++n > 5000) begin fails++; report_and_stop; end
    end
    {req_op, req_row, req_col, req_len} = r[39:2];
    req_valid = 1;
    exp_col = req_col;
    nb = 0;
    @(negedge clock);
    req_valid = 0;
    // A refusal answers at once; the last read byte lands one cycle after done
    tail = int'(done);
    while (tail < 3 || rd_valid) begin
      @(negedge clock);
      rd_ready = n[1];
      if (done || tail > 0) tail++;
      if (rd_valid && rd_ready) begin
        chk(rd_data, exp_col[7:0] ^ 8'h5A, "read byte");
        exp_col++;
        nb++;
      end
      if (++n > 9000) begin fails++; report_and_stop; end
    end
    chk({7'h0, refused}, {7'h0, r[1]}, "refused");
    chk({6'h0, failed, timed_out}, {6'h0, r[0], 1'b0}, "failed");
    if (r[39:37] == 3'h0 && !r[1]) chk(nb[7:0], r[9:2], "byte count");
    if (r[39:37] == 3'h3) chk(status_byte, 8'h60, "status");
  endtask : do_req
  initial begin
    repeat (3) @(negedge clock);
    chk({ce_n, we_n, output_strobe_n, wp_n, req_ready, io_oe, cle, ale}, 8'hE0, "reset pins");
    rst_n = 1;
    foreach (rows[i]) do_req(rows[i]);
    fail = 1;
    do_req({3'h1, 15'h40, 10'h0, 10'h4, 2'h1});
    chk(status_byte, 8'h61, "fail status");
    fail = 0;
    do_req({3'h0, 15'h40, 10'h0, 10'h4, 2'h2});
    arm = 1;
    do_req({3'h1, 15'h60, 10'h0, 10'h4, 2'h1});
    arm = 0;
    wp_hold = 0;
    mark_block = 10'h005;
    mark_bad = 1;
    @(negedge clock);
    mark_bad = 0;
    do_req({3'h0, 15'hA0, 10'h0, 10'h4, 2'h2});
    do_req({3'h3, 15'h0, 10'h0, 10'h0, 2'h0});
    report_and_stop;
  end
endmodule : tb
